// ### core/bla_master.sv
module bla_master
  import bla_pkg::*;
#(
  parameter int AW = 32,
  parameter int LEN_W = 16
) (
  input wire logic clock,
  input wire logic resetn,
  input wire logic ce,
  bla_bus_if.mst bus,
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire bla_op_e cmd_op,
  input wire logic [1:0] cmd_size,
  input wire logic cmd_big,
  input wire logic [AW-3:0] cmd_waddr,
  input wire logic [1:0] cmd_off,
  input wire logic [AW-3:0] cmd_src,
  input wire logic [AW-3:0] cmd_dst,
  input wire logic [LEN_W-1:0] cmd_len,
  input wire logic [63:0] cmd_value,
  output logic done,
  output logic err
);

  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef enum logic [1:0] {
    M_IDLE,
    M_WR,
    M_RD,
    M_RWAIT
  } bla_mst_e;

  typedef struct packed {
    bla_mst_e st;
    logic copy;
    logic [LEN_W-1:0] cnt;
    logic [AW-3:0] src;
    logic [AW-3:0] dst;
    logic [CPU_W-1:0] hi;
    logic hi_pend;
    logic [AW-1:0] addr;
    logic [CPU_W-1:0] wd;
    logic [3:0] be;
    logic rd;
    logic wr;
    logic rdy;
    logic done;
    logic err;
  } bla_mst_s;

  bla_mst_s q, n;

  // ----------------------------------------
  // Helpers
  // ----------------------------------------

  // Only seven aligned forms exist; the two-word store is two word forms
  function automatic logic legal(input logic [1:0] sz, input logic [1:0] off);
    if (sz == SZ_BYTE) begin
      return 1'b1;
    end
    if (sz == SZ_HALF) begin
      return !off[0];
    end
    return off == 2'h0;
  endfunction

  function automatic logic [3:0] be_for(input logic [1:0] sz, input logic [1:0] off);
    if (sz == SZ_BYTE) begin
      return BE_BYTE0 << off;
    end
    if (sz == SZ_HALF) begin
      return off[1] ? BE_HALF_HI : BE_HALF_LO;
    end
    return BE_WORD;
  endfunction

  // Word address to byte address; the low bits are always zero
  function automatic logic [AW-1:0] byte_addr(input logic [AW-3:0] w);
    return {w, 2'h0};
  endfunction

  // Reorders a big-endian value so its lowest offset byte is on lane 0.
  // The arithmetic view changes, the lane order at the bus does not.
  function automatic logic [63:0] to_lanes(
    input logic [63:0] v,
    input logic [1:0] sz,
    input logic big
  );
    logic [63:0] r;
    int nb;
    int j;
    r = '0;
    nb = 1 << sz;
    for (int i = 0; i < 8; i++) begin
      if (i < nb) begin
        j = big ? nb - 1 - i : i;
        r[BYTE_W*i +: BYTE_W] = v[BYTE_W*j +: BYTE_W];
      end
    end
    return r;
  endfunction

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    logic [63:0] sv;
    sv = to_lanes(cmd_value, cmd_size, cmd_big);
    n = q;
    n.done = 1'b0;
    n.err = 1'b0;
    case (q.st)
      M_IDLE: begin
        n.rdy = 1'b1;
        if (cmd_valid && q.rdy) begin
          if (cmd_op == OP_STORE) begin
            if (!legal(cmd_size, cmd_off)) begin
              n.err = 1'b1;
            end else begin
              n.rdy = 1'b0;
              n.copy = 1'b0;
              n.cnt = '0;
              n.addr = {cmd_waddr, cmd_off};
              // Lane k of the bus always carries byte offset k
              n.wd = sv[CPU_W-1:0] << (BYTE_W * int'(cmd_off));
              n.be = be_for(cmd_size, cmd_off);
              n.hi = sv[63:CPU_W];
              n.hi_pend = (cmd_size == SZ_DWORD);
              n.wr = 1'b1;
              n.st = M_WR;
            end
          end else if (cmd_len == '0) begin
            n.done = 1'b1;
          end else begin
            n.rdy = 1'b0;
            n.copy = 1'b1;
            n.cnt = cmd_len;
            n.src = cmd_src;
            n.dst = cmd_dst;
            n.hi_pend = 1'b0;
            n.addr = byte_addr(cmd_src);
            n.be = BE_WORD;
            n.rd = 1'b1;
            n.st = M_RD;
          end
        end
      end

      M_WR: begin
        if (!bus.wait_req) begin
          n.wr = 1'b0;
          if (q.hi_pend) begin
            // Upper word follows at the next word address
            n.addr = q.addr + AW'(4);
            n.wd = q.hi;
            n.be = BE_WORD;
            n.hi_pend = 1'b0;
            n.wr = 1'b1;
          end else if (q.copy && q.cnt != LEN_W'(1)) begin
            n.cnt = q.cnt - 1'b1;
            n.src = q.src + 1'b1;
            n.dst = q.dst + 1'b1;
            n.addr = byte_addr(q.src + 1'b1);
            n.be = BE_WORD;
            n.rd = 1'b1;
            n.st = M_RD;
          end else begin
            n.cnt = '0;
            n.done = 1'b1;
            n.rdy = 1'b1;
            n.st = M_IDLE;
          end
        end
      end

      M_RD: begin
        if (!bus.wait_req) begin
          n.rd = 1'b0;
          n.st = M_RWAIT;
        end
      end

      M_RWAIT: begin
        // One word in flight: read, then write it, then next read
        if (bus.rvalid) begin
          n.wd = bus.rdata;
          n.be = BE_WORD;
          n.addr = byte_addr(q.dst);
          n.wr = 1'b1;
          n.st = M_WR;
        end
      end

      default: begin
        n.st = M_IDLE;
      end
    endcase
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      q <= '0;
      q.rd <= RST_REQ;
      q.wr <= RST_REQ;
    end else if (ce) begin
      q <= n;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign bus.addr = q.addr;
  assign bus.be = q.be;
  assign bus.wdata = q.wd;
  assign bus.rd = q.rd;
  assign bus.wr = q.wr;
  assign cmd_ready = q.rdy;
  assign done = q.done;
  assign err = q.err;

endmodule

// ### core/bla_pkg.sv
// Operation
// - Byte offset 0 rides on bits 7:0
// - Same slave byte, same lane, any master
// - Wide to narrow: lower bytes go first
// - Narrow to wide: steer onto addressed lanes
// - Copy reads ascend from source base
// - Copy writes ascend from destination base
// - Least significant byte at lowest offset; stores with cmd_big set put the most significant byte there
// - Wide stores: low word, lower address, first
// - Only seven aligned processor write forms
// - Byte writes use one-hot byte enables
// - Halfword enables 0011/1100, word 1111
// - Processor master presents compliant lane order
// - Big-endian values still leave on little lanes
// - Word addresses gain zero low bits
package bla_pkg;

  // ----------------------------------------
  // Widths and counts
  // ----------------------------------------
  localparam int BYTE_W = 8;
  localparam int CPU_W = 32;
  localparam int WORD_SHIFT = 2;
  localparam int BEAT_W = 8;

  // ----------------------------------------
  // Processor byte-enable forms
  // ----------------------------------------
  localparam logic [3:0] BE_BYTE0 = 4'h1;
  localparam logic [3:0] BE_HALF_LO = 4'h3;
  localparam logic [3:0] BE_HALF_HI = 4'hC;
  localparam logic [3:0] BE_WORD = 4'hF;

  // ----------------------------------------
  // Store sizes as log2 of bytes
  // ----------------------------------------
  localparam logic [1:0] SZ_BYTE = 2'h0;
  localparam logic [1:0] SZ_HALF = 2'h1;
  localparam logic [1:0] SZ_WORD = 2'h2;
  localparam logic [1:0] SZ_DWORD = 2'h3;

  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic RST_WAIT = 1'b0;
  localparam logic RST_REQ = 1'b0;

  typedef enum logic {
    OP_STORE,
    OP_COPY
  } bla_op_e;

endpackage

// ### core/bla_bus_if.sv
interface bla_bus_if #(
  parameter int MW = 32,
  parameter int AW = 32
) (
  input wire logic clock
);
  logic [AW-1:0] addr;
  logic [MW/8-1:0] be;
  logic [MW-1:0] wdata;
  logic rd;
  logic wr;
  logic wait_req;
  logic [MW-1:0] rdata;
  logic rvalid;

  modport mst (
    output addr, be, wdata, rd, wr,
    input wait_req, rdata, rvalid, clock
  );

  modport adp (
    input addr, be, wdata, rd, wr, clock,
    output wait_req, rdata, rvalid
  );
endinterface

// ### core/bla_adapter.sv
module bla_adapter
  import bla_pkg::*;
#(
  parameter int MW = 32,
  parameter int SW = 16,
  parameter int AW = 32
) (
  input wire logic clock,
  input wire logic resetn,
  input wire logic ce,
  bla_bus_if.adp bus,
  output logic [AW-1:0] s_addr,
  output logic s_wr,
  output logic s_rd,
  output logic [SW-1:0] s_wdata,
  output logic [SW/8-1:0] s_be,
  input wire logic s_wait,
  input wire logic [SW-1:0] s_rdata,
  input wire logic s_rvalid
);
  localparam int MB = MW / BYTE_W;
  localparam int SB = SW / BYTE_W;
  localparam bit WIDE = MW > SW;
  localparam int XW = WIDE ? MW : SW;
  localparam int NB = WIDE ? MW / SW : 1;
  localparam int ALN = WIDE ? MB : SB;

  typedef enum logic [1:0] {A_IDLE, A_SREQ, A_SRD} bla_ast_e;

  typedef struct packed {
    bla_ast_e st;
    logic wr;
    logic [AW-1:0] addr;
    logic [MW-1:0] wd;
    logic [MB-1:0] be;
    logic [BEAT_W-1:0] beat;
    logic [MW-1:0] acc;
    logic m_wait;
    logic m_rv;
    logic [MW-1:0] m_rd;
    logic [AW-1:0] s_addr;
    logic s_wr;
    logic s_rd;
    logic [SW-1:0] s_wd;
    logic [SB-1:0] s_be;
  } bla_ast_s;

  bla_ast_s q, n;

  // Bit offset of the current beat inside the wider of the two words
  function automatic int lane_shift(input logic [AW-1:0] a, input logic [BEAT_W-1:0] b);
    if (WIDE) begin
      return int'(b) * SW;
    end
    return (int'(a & AW'(SB - 1)) / MB) * MW;
  endfunction

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    logic [XW-1:0] xd;
    logic [XW/8-1:0] xb;
    logic [XW-1:0] xr;
    logic last;
    int sh;
    xd = '0;
    xb = '0;
    xr = '0;
    sh = 0;
    last = (int'(q.beat) == NB - 1);
    n = q;
    n.m_rv = 1'b0;
    if (WIDE) begin
      xr = XW'(s_rdata) << lane_shift(q.addr, q.beat);
    end else begin
      xr = XW'(s_rdata) >> lane_shift(q.addr, q.beat);
    end
    case (q.st)
      A_IDLE: begin
        if (bus.rd || bus.wr) begin
          n.st = A_SREQ;
          n.wr = bus.wr;
          n.addr = bus.addr;
          n.wd = bus.wdata;
          n.be = bus.be;
          n.beat = '0;
          n.acc = '0;
          n.m_wait = 1'b1;
        end
      end
      A_SREQ: begin
        if (!s_wait) begin
          if (!q.wr) begin
            n.st = A_SRD;
          end else if (last) begin
            n.st = A_IDLE;
            n.m_wait = 1'b0;
          end else begin
            n.beat = q.beat + 1'b1;
          end
        end
      end
      A_SRD: begin
        if (s_rvalid) begin
          n.acc = q.acc | xr[MW-1:0];
          if (last) begin
            n.st = A_IDLE;
            n.m_wait = 1'b0;
            n.m_rv = 1'b1;
            n.m_rd = n.acc;
          end else begin
            n.beat = q.beat + 1'b1;
            n.st = A_SREQ;
          end
        end
      end
      default: n.st = A_IDLE;
    endcase

    // Slave side follows the captured request; same address always hits same lane
    sh = lane_shift(n.addr, n.beat);
    if (WIDE) begin
      xd = XW'(n.wd) >> sh;
      xb = (XW/8)'(n.be) >> (sh / BYTE_W);
    end else begin
      xd = XW'(n.wd) << sh;
      xb = (XW/8)'(n.be) << (sh / BYTE_W);
    end
    n.s_addr = (n.addr & ~AW'(ALN - 1)) + AW'(int'(n.beat) * SB);
    n.s_be = xb[SB-1:0];
    for (int i = 0; i < SB; i++) begin
      // Disabled lanes carry zero so nothing stale leaks out
      n.s_wd[BYTE_W*i +: BYTE_W] = n.s_be[i] ? xd[BYTE_W*i +: BYTE_W] : 8'h00;
    end
    n.s_rd = (n.st == A_SREQ) && !n.wr;
    n.s_wr = (n.st == A_SREQ) && n.wr;
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      q <= '0;
      q.m_wait <= RST_WAIT;
    end else if (ce) begin
      q <= n;
    end
  end

  // Byte 0 stays on bits 7:0 on both ports, no renaming
  assign bus.wait_req = q.m_wait;
  assign bus.rvalid = q.m_rv;
  assign bus.rdata = q.m_rd;
  assign s_addr = q.s_addr;
  assign s_wr = q.s_wr;
  assign s_rd = q.s_rd;
  assign s_wdata = q.s_wd;
  assign s_be = q.s_be;

endmodule

// ### tb/bla_checker.sv
module bla_checker (
  input wire logic clock,
  input wire logic resetn,
  input wire logic [31:0] addr,
  input wire logic [3:0] be,
  input wire logic [31:0] wdata,
  input wire logic rd,
  input wire logic wr,
  input wire logic wait_req,
  input wire logic [31:0] rdata,
  input wire logic rvalid
);
  timeunit 1ns;
  timeprecision 1ns;
  // ----------------------------------------
  // Bus relations between master and adapter
  // ----------------------------------------
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!resetn);

  chk_write_forms: assert property (wr |-> be inside {4'h1, 4'h2, 4'h4, 4'h8, 4'h3, 4'hC, 4'hF})
    else $error("illegal byte enable form");
  chk_byte_lane: assert property (wr && $onehot(be) |-> be == (4'h1 << addr[1:0]))
    else $error("byte enable off its lane");
  chk_half_low: assert property (wr && be == 4'h3 |-> addr[1:0] == 2'h0)
    else $error("low halfword at wrong offset");
  chk_half_high: assert property (wr && be == 4'hC |-> addr[1:0] == 2'h2)
    else $error("high halfword at wrong offset");
  chk_word_aligned: assert property (wr && be == 4'hF |-> addr[1:0] == 2'h0)
    else $error("word write not aligned");
  chk_one_dir: assert property (!(rd && wr))
    else $error("read and write together");
  chk_take_busy: assert property ((rd || wr) && !wait_req |=> wait_req)
    else $error("taken request did not raise wait");
  chk_read_end: assert property (rvalid |-> $fell(wait_req) ##1 !rvalid)
    else $error("read valid not at end of wait");
  chk_wait_bound: assert property ($rose(wait_req) |-> ##[1:40] !wait_req)
    else $error("wait held too long");
  // Read data must not wander between reads, masters rely on it
  chk_rdata_hold: assert property ($changed(rdata) |-> rvalid)
    else $error("read data changed without valid");
endmodule

// ### tb/test_byte_lane_width_adapter.sv
module test_byte_lane_width_adapter
  import bla_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  // ----------------------------------------
  // Stimulus and slave memory
  // ----------------------------------------
  logic clock = 1'b0, resetn = 1'b0, cmd_valid = 1'b0, cmd_big = 1'b0, stall_on = 1'b0;
  bla_op_e cmd_op = OP_STORE;
  logic [1:0] cmd_size = 2'h0, cmd_off = 2'h0, s_be;
  logic [29:0] cmd_waddr = 30'h0, cmd_src = 30'h0, cmd_dst = 30'h0;
  logic [15:0] cmd_len = 16'h0, s_wdata, s_rdata = 16'h0;
  logic [63:0] cmd_value = 64'h0;
  logic cmd_ready, done, err, s_wr, s_rd, s_wait = 1'b0, s_rvalid = 1'b0, dn, er;
  logic [31:0] s_addr, exp_wa, exp_ra;
  logic [7:0] mem [256] = '{default: 8'hEE};
  logic ce = 1'b1;
  int error_cnt = 0, samples_checked = 0, cyc = 0;
  // Forms: {big, size, offset}; expected word after storing into all-EE memory
  localparam logic [7:0] TCFG [9] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h06, 8'h08, 8'h18,
    8'h16};
  localparam logic [31:0] TEXP [9] = '{32'hEEEEEE0A, 32'hEEEE0AEE, 32'hEE0AEEEE, 32'h0AEEEEEE,
    32'hEEEE0A0B, 32'h0A0BEEEE, 32'h0A0B0C0D, 32'h0D0C0B0A, 32'h0B0AEEEE};

  always #50 clock = ~clock;

  bla_bus_if bus_if (.clock(clock));
  bla_master u_bla_master (.clock(clock), .resetn(resetn), .ce(ce),
    .bus(bus_if), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_op(cmd_op),
    .cmd_size(cmd_size), .cmd_big(cmd_big), .cmd_waddr(cmd_waddr), .cmd_off(cmd_off),
    .cmd_src(cmd_src), .cmd_dst(cmd_dst), .cmd_len(cmd_len), .cmd_value(cmd_value),
    .done(done), .err(err));
  bla_adapter u_bla_adapter (.clock(clock), .resetn(resetn),
    .ce(ce), .bus(bus_if), .s_addr(s_addr), .s_wr(s_wr), .s_rd(s_rd), .s_wdata(s_wdata),
    .s_be(s_be), .s_wait(s_wait), .s_rdata(s_rdata), .s_rvalid(s_rvalid));
  bla_checker u_bla_checker (.clock(clock), .resetn(resetn), .addr(bus_if.addr),
    .be(bus_if.be), .wdata(bus_if.wdata), .rd(bus_if.rd), .wr(bus_if.wr),
    .wait_req(bus_if.wait_req), .rdata(bus_if.rdata), .rvalid(bus_if.rvalid));

  task automatic chk_addr(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: slave address %h, want %h", $time, got, exp);
    end
  endtask

  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: memory byte %h, want %h", $time, got, exp);
    end
  endtask

  task automatic chk_flag(input logic got, input logic exp);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: flag %b, want %b", $time, got, exp);
    end
  endtask

  // Stalls alternate, so s_wait refuses every second edge while stall_on is set; a beat can still be taken at once
  always @(posedge clock) begin
    // Expected slave addresses start from the base of the offered command
    if (cmd_valid) begin
      exp_ra <= {cmd_src, 2'h0};
      exp_wa <= (cmd_op == OP_STORE) ? {cmd_waddr, 2'h0} : {cmd_dst, 2'h0};
    end
    s_wait <= stall_on & ~s_wait;
    s_rvalid <= s_rd & ~s_wait;
    if (s_rd && !s_wait) begin
      s_rdata <= {mem[8'(s_addr + 1)], mem[s_addr[7:0]]};
      chk_addr(s_addr, exp_ra);
      exp_ra <= exp_ra + 32'h2;
    end else begin
      s_rdata <= ~s_rdata;
    end
    if (s_wr && !s_wait) begin
      for (int k = 0; k < 2; k++) begin
        if (s_be[k]) mem[8'(s_addr + k)] <= s_wdata[8*k+:8];
      end
      chk_addr(s_addr, exp_wa);
      exp_wa <= exp_wa + 32'h2;
    end
  end

  task automatic run(output logic d, output logic e);
    int n;
    d = 1'b0;
    e = 1'b0;
    cmd_valid <= 1'b1;
    n = 0;
    @(negedge clock);
    while (cmd_ready !== 1'b1 && n < 50) begin
      @(negedge clock);
      n++;
    end
    @(posedge clock);
    cmd_valid <= 1'b0;
    for (n = 0; n < 100 && !d && !e; n++) begin
      @(negedge clock);
      d = done;
      e = err;
    end
    // A store completes when taken; the slave beats still follow
    while (bus_if.wait_req !== 1'b0 && n < 200) begin
      @(negedge clock);
      n++;
    end
  endtask

  task automatic store(input logic [7:0] cfg, input logic [29:0] wa, input logic [63:0] v);
    @(posedge clock);
    cmd_op <= OP_STORE;
    cmd_big <= cfg[4];
    cmd_size <= cfg[3:2];
    cmd_off <= cfg[1:0];
    cmd_waddr <= wa;
    cmd_value <= v;
    run(dn, er);
  endtask

  task automatic copy(input logic [29:0] src, input logic [29:0] dst, input logic [15:0] len);
    @(posedge clock);
    cmd_op <= OP_COPY;
    cmd_src <= src;
    cmd_dst <= dst;
    cmd_len <= len;
    run(dn, er);
  endtask

  task automatic print_verdict();
    $display("errors %0d, checks %0d", error_cnt, samples_checked);
    if (error_cnt == 0 && samples_checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  always @(posedge clock) begin
    cyc++;
    if (cyc == 5000) begin
      error_cnt++;
      print_verdict();
    end
  end

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  initial begin
    repeat (6) @(posedge clock);
    resetn <= 1'b1;
    for (int i = 0; i < 9; i++) begin
      store(TCFG[i], 30'(i + 1), 64'h0A0B0C0D >> (32 - (8 << TCFG[i][3:2])));
      chk_flag(dn, 1'b1);
      for (int k = 0; k < 4; k++) chk_byte(mem[4*i+4+k], TEXP[i][8*k+:8]);
    end
    store(8'h0C, 30'h10, 64'h0807060504030201);
    for (int k = 0; k < 8; k++) chk_byte(mem[64+k], 8'(k + 1));
    store(8'h05, 30'h14, 64'h0A0B);
    chk_flag(er, 1'b1);
    chk_flag(dn, 1'b0);
    chk_byte(mem[81], 8'hEE);
    stall_on <= 1'b1;
    copy(30'h10, 30'h18, 16'h2);
    for (int k = 0; k < 8; k++) chk_byte(mem[96+k], 8'(k + 1));
    copy(30'h10, 30'h1C, 16'h0);
    chk_flag(dn, 1'b1);
    chk_byte(mem[112], 8'hEE);
    // Low enable freezes both ends: the offered store must leave no trace
    @(posedge clock);
    ce <= 1'b0;
    store(8'h08, 30'h1E, 64'h11223344);
    chk_flag(dn, 1'b0);
    chk_byte(mem[120], 8'hEE);
    @(posedge clock);
    ce <= 1'b1;
    store(8'h08, 30'h1E, 64'h11223344);
    chk_flag(dn, 1'b1);
    chk_byte(mem[120], 8'h44);
    print_verdict();
  end
endmodule
